/* File: logic/rrsb_pkg.sv */
// package for the rotate-right / subtract-with-borrow datapath slice
// assumes a single core clock domain; shared by design and bench
package rrsb_pkg;
   localparam int DATA_W = 8;
   localparam int SYNC_STAGES = 2;
   localparam int NIB_W = 4;

   // operation codes presented by the instruction decoder
   typedef enum logic [2:0] {
      RRSB_OP_NONE = 3'h0,
      RRSB_OP_ROT_RIGHT_MEM = 3'h1,
      RRSB_OP_ROT_RIGHT_TO_ACC = 3'h2,
      RRSB_OP_ROT_RIGHT_CARRY_MEM = 3'h3,
      RRSB_OP_ROT_RIGHT_CARRY_TO_ACC = 3'h4,
      RRSB_OP_SUB_BORROW_TO_ACC = 3'h5,
      RRSB_OP_SUB_BORROW_TO_MEM = 3'h6
   } rrsb_op_t;

   // values after reset
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic [7:0] ADDR_RST = 8'h00;
endpackage

/* File: logic/rrsb_core.sv */
// datapath slice: right rotations and subtract-with-borrow on a data-memory byte
// assumes the decoder presents op, address and the fetched operand in one cycle
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns

module rrsb_core #(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire rrsb_pkg::rrsb_op_t op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic acc_load,
   input wire logic [7:0] acc_load_data,
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_waddr,
   output logic [7:0] mem_wdata,
   output logic [7:0] accumulator,
   output logic carry_flag,
   output logic zero_flag,
   output logic overflow_flag,
   output logic aux_carry_flag,
   output logic ext_sign_carry_flag,
   output logic ext_zero_carry_flag
);
   // ===================================
   // elaboration checks
   if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
      $error("rrsb_core: ADDR_W out of range");
   end

   if (rrsb_pkg::SYNC_STAGES < 2) begin : g_bad_sync
      $error("rrsb_core: reset release needs two or more stages");
   end

   if (rrsb_pkg::NIB_W * 2 != rrsb_pkg::DATA_W) begin : g_bad_nib
      $error("rrsb_core: nibble must be half the data byte");
   end

   // ===================================
   // reset release
   // assertion is asynchronous, release is timed to the clock so no flop leaves reset mid-setup
   logic [rrsb_pkg::SYNC_STAGES-1:0] rst_sync_q;
   logic rst_core_n;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= '0;
      end else begin
         rst_sync_q <= {rst_sync_q[rrsb_pkg::SYNC_STAGES-2:0], 1'b1};
      end
   end

   assign rst_core_n = rst_sync_q[rrsb_pkg::SYNC_STAGES-1];

   // ===================================
   // state and next values
   logic [7:0] accum_q;
   logic [7:0] accum_d;

   logic carry_q;
   logic carry_d;

   logic zero_q;
   logic zero_d;

   logic ovf_q;
   logic ovf_d;

   logic nib_q;
   logic nib_d;

   logic sgn_q;
   logic sgn_d;

   logic zchain_q;
   logic zchain_d;

   logic we_q;
   logic we_d;

   logic [ADDR_W-1:0] waddr_q;
   logic [ADDR_W-1:0] waddr_d;

   logic [7:0] wdata_q;
   logic [7:0] wdata_d;

   // ===================================
   // operation decode
   // codes 0 and 7 match nothing here; only the address capture sees them
   wire is_rot_mem = op_valid && (op_code == rrsb_pkg::RRSB_OP_ROT_RIGHT_MEM);
   wire is_rot_acc = op_valid && (op_code == rrsb_pkg::RRSB_OP_ROT_RIGHT_TO_ACC);
   wire is_crot_mem = op_valid && (op_code == rrsb_pkg::RRSB_OP_ROT_RIGHT_CARRY_MEM);
   wire is_crot_acc = op_valid && (op_code == rrsb_pkg::RRSB_OP_ROT_RIGHT_CARRY_TO_ACC);
   wire is_sub_acc = op_valid && (op_code == rrsb_pkg::RRSB_OP_SUB_BORROW_TO_ACC);
   wire is_sub_mem = op_valid && (op_code == rrsb_pkg::RRSB_OP_SUB_BORROW_TO_MEM);

   // groups of ops that share one flag update, and the ops that write memory
   wire is_sub = is_sub_acc || is_sub_mem;
   wire is_crot = is_crot_mem || is_crot_acc;
   wire writes_mem = is_rot_mem || is_crot_mem || is_sub_mem;

   // ===================================
   // right rotations
   logic [6:0] rot_low;

   for (genvar i = 0; i < 7; i++) begin : g_rot
      assign rot_low[i] = mem_rdata[i+1];
   end

   wire [7:0] rot_plain = {mem_rdata[0], rot_low};
   wire [7:0] rot_carry = {carry_q, rot_low};
   wire rot_out = mem_rdata[0];

   // ===================================
   // subtract with borrow
   // ripple borrow: slower than lookahead, but the nibble and sign borrows come out for free
   logic [8:0] borrow;
   logic [7:0] diff;
   logic [8:0] nz_chain;

   assign borrow[0] = ~carry_q;
   assign nz_chain[0] = 1'b0;

   for (genvar i = 0; i < 8; i++) begin : g_sub
      assign diff[i] = accum_q[i] ^ mem_rdata[i] ^ borrow[i];
      assign borrow[i+1] = (~accum_q[i] & mem_rdata[i]) | (~(accum_q[i] ^ mem_rdata[i]) & borrow[i]);
      assign nz_chain[i+1] = nz_chain[i] | diff[i];
   end

   wire diff_neg = borrow[8];
   wire diff_zero = ~nz_chain[8];
   wire diff_ovf = borrow[8] ^ borrow[7];
   wire nib_borrow = borrow[rrsb_pkg::NIB_W];
   wire diff_sgn = diff[7] ^ diff_ovf;

   // ===================================
   // accumulator
   // a datapath op that writes the accumulator wins over a decoder load in the same cycle
   assign accum_d = is_sub_acc ? diff :
      is_rot_acc ? rot_plain :
      is_crot_acc ? rot_carry :
      acc_load ? acc_load_data : accum_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         accum_q <= rrsb_pkg::ACC_RST;
      end else begin
         accum_q <= accum_d;
      end
   end

   assign accumulator = accum_q;

   // ===================================
   // carry
   assign carry_d = is_sub ? ~diff_neg :
      is_crot ? rot_out : carry_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         carry_q <= rrsb_pkg::FLAG_RST;
      end else begin
         carry_q <= carry_d;
      end
   end

   assign carry_flag = carry_q;

   // ===================================
   // zero
   assign zero_d = is_sub ? diff_zero : zero_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         zero_q <= rrsb_pkg::FLAG_RST;
      end else begin
         zero_q <= zero_d;
      end
   end

   assign zero_flag = zero_q;

   // ===================================
   // overflow
   assign ovf_d = is_sub ? diff_ovf : ovf_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ovf_q <= rrsb_pkg::FLAG_RST;
      end else begin
         ovf_q <= ovf_d;
      end
   end

   assign overflow_flag = ovf_q;

   // ===================================
   // nibble carry
   // polarity follows carry: 1 means no borrow out of the low nibble
   assign nib_d = is_sub ? ~nib_borrow : nib_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         nib_q <= rrsb_pkg::FLAG_RST;
      end else begin
         nib_q <= nib_d;
      end
   end

   assign aux_carry_flag = nib_q;

   // ===================================
   // extended sign
   // true sign of the difference, right even when the byte overflowed
   assign sgn_d = is_sub ? diff_sgn : sgn_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         sgn_q <= rrsb_pkg::FLAG_RST;
      end else begin
         sgn_q <= sgn_d;
      end
   end

   assign ext_sign_carry_flag = sgn_q;

   // ===================================
   // extended zero
   // set only when this subtract's byte and the previous subtract's byte are both zero
   assign zchain_d = is_sub ? (diff_zero & zero_q) : zchain_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         zchain_q <= rrsb_pkg::FLAG_RST;
      end else begin
         zchain_q <= zchain_d;
      end
   end

   assign ext_zero_carry_flag = zchain_q;

   // ===================================
   // write strobe
   // a write pulse lasts exactly one cycle after the op
   assign we_d = writes_mem;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         we_q <= 1'b0;
      end else begin
         we_q <= we_d;
      end
   end

   assign mem_we = we_q;

   // ===================================
   // write address
   // captured on every op, even codes that do nothing
   assign waddr_d = op_valid ? op_addr : waddr_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         waddr_q <= ADDR_W'(rrsb_pkg::ADDR_RST);
      end else begin
         waddr_q <= waddr_d;
      end
   end

   assign mem_waddr = waddr_q;

   // ===================================
   // write data
   // holds after the pulse so a slow memory may sample late
   assign wdata_d = is_sub_mem ? diff :
      is_rot_mem ? rot_plain :
      is_crot_mem ? rot_carry : wdata_q;

   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         wdata_q <= 8'h00;
      end else begin
         wdata_q <= wdata_d;
      end
   end

   assign mem_wdata = wdata_q;

endmodule

/* File: verif/rrsb_props.sv */
// checker: properties on the datapath slice ports
// assumes one clock and no op before the reset sync ends
`timescale 1ns/1ns
// ==========
// checker
module rrsb_props #(parameter int ADDR_W = 8) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire logic acc_load,
   input wire logic mem_we,
   input wire logic carry_flag,
   input wire logic zero_flag,
   input wire logic overflow_flag,
   input wire logic aux_carry_flag,
   input wire logic ext_sign_carry_flag,
   input wire logic ext_zero_carry_flag,
   input wire rrsb_pkg::rrsb_op_t op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [ADDR_W-1:0] mem_waddr,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] acc_load_data,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] accumulator
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire s = op_valid && (op_code == 3'h5 || op_code == 3'h6);
   wire [7:0] r = {mem_rdata[0], mem_rdata[7:1]};
   wire [7:0] rc = {carry_flag, mem_rdata[7:1]};
   wire [7:0] d = accumulator - mem_rdata - !carry_flag;
   wire [8:0] m9 = mem_rdata + !carry_flag;
   wire [4:0] n5 = mem_rdata[3:0] + !carry_flag;
   wire ovf = (accumulator[7] ^ mem_rdata[7]) & (accumulator[7] ^ d[7]);
   a_rot_mem: assert property (op_valid && op_code == 3'h1 |=> mem_we && mem_wdata == $past(r)
      && mem_waddr == $past(op_addr) && $stable(carry_flag)) else $error("rotate to memory wrong");
   a_rot_acc: assert property (op_valid && op_code == 3'h2 |=> !mem_we && accumulator == $past(r)
      && $stable(carry_flag)) else $error("rotate to accumulator wrong");
   a_rotc_mem: assert property (op_valid && op_code == 3'h3 |=> mem_we && mem_wdata == $past(rc))
      else $error("carry rotate to memory wrong");
   a_rotc_carry: assert property (op_valid && (op_code == 3'h3 || op_code == 3'h4) |=>
      carry_flag == $past(mem_rdata[0]) && $stable({zero_flag, overflow_flag, aux_carry_flag}))
      else $error("carry rotate flags wrong");
   a_rotc_acc: assert property (op_valid && op_code == 3'h4 |=> !mem_we && accumulator == $past(rc))
      else $error("carry rotate to accumulator wrong");
   a_sub_acc: assert property (op_valid && op_code == 3'h5 |=> !mem_we && accumulator == $past(d))
      else $error("subtract to accumulator wrong");
   a_sub_mem: assert property (op_valid && op_code == 3'h6 |=> mem_we && mem_wdata == $past(d)
      && accumulator == $past(acc_load ? acc_load_data : accumulator)) else $error("subtract to memory wrong");
   a_sub_carry: assert property (s |=> carry_flag == ($past({1'b0, accumulator}) >= $past(m9)))
      else $error("subtract carry wrong");
   a_sub_flags: assert property (s |=> zero_flag == ($past(d) == 8'h00) && ext_zero_carry_flag ==
      (zero_flag && $past(zero_flag)) && ext_sign_carry_flag == ($past(d[7]) ^ overflow_flag))
      else $error("subtract flags wrong");
   a_sub_nibble: assert property (s |=> overflow_flag == $past(ovf) &&
      aux_carry_flag == ($past({1'b0, accumulator[3:0]}) >= $past(n5))) else $error("nibble or overflow wrong");
endmodule
bind rrsb_core rrsb_props #(.ADDR_W(ADDR_W)) u_props (.*);

/* File: verif/testbench.sv */
// bench: directed and random ops against an integer model
// assumes the datapath slice alone; the bench stands in for decoder and memory
`timescale 1ns/1ns
// ==========
// bench
module testbench;
   logic clk_sys = 0, rst_n = 0, op_valid = 0, acc_load = 0;
   rrsb_pkg::rrsb_op_t op_code = rrsb_pkg::RRSB_OP_NONE;
   logic [7:0] op_addr = 8'h00, mem_rdata = 8'h00, acc_load_data = 8'h00, mem_waddr, mem_wdata, accumulator;
   logic mem_we, carry_flag, zero_flag, overflow_flag, aux_carry_flag, ext_sign_carry_flag, ext_zero_carry_flag;
   logic [7:0] ea = 8'h00, ew = 8'h00, ed = 8'h00;
   logic [6:0] ef = 7'h00; // carry zero ov aux sign zero-chain write
   int n_fail = 0, cmp_count = 0, dd, pend = 0;
   rrsb_core u_dut (.*);
   always #2 clk_sys = ~clk_sys;
   task automatic cmp_state(input logic [23:0] g, input logic [23:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t state got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_wdata(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t write data got %h exp %h", $time, g, e);
      end
   endtask
   // negedge sampling: outputs settled, model already advanced
   always @(negedge clk_sys) if (pend) begin
      cmp_state({accumulator, mem_waddr, carry_flag, zero_flag, overflow_flag, aux_carry_flag, ext_sign_carry_flag,
         ext_zero_carry_flag, mem_we, 1'b0}, {ea, ed, ef, 1'b0});
      if (ef[0]) cmp_wdata(mem_wdata, ew);
   end
   task automatic op(input logic [2:0] k, input logic [7:0] m, input logic l);
      logic v;
      v = (k != 3'h0) | m[0];
      op_valid <= v;
      op_code <= rrsb_pkg::rrsb_op_t'(k);
      mem_rdata <= m;
      op_addr <= m ^ 8'h5A;
      acc_load <= l;
      acc_load_data <= ~m;
      @(posedge clk_sys);
      pend = 1;
      if (v) ed = m ^ 8'h5A;
      ef[0] = v && k inside {3'h1, 3'h3, 3'h6};
      if (!v) ;
      else if (k == 3'h3 || k == 3'h4) begin
         ew = {ef[6], m[7:1]};
         ef[6] = m[0];
      end else if (k == 3'h5 || k == 3'h6) begin
         dd = ea - m - !ef[6];
         ew = dd[7:0];
         ef[3] = {1'b0, ea[3:0]} >= m[3:0] + !ef[6];
         ef[4] = (ea[7] ^ m[7]) & (ea[7] ^ ew[7]);
         ef[6] = dd >= 0;
         ef[1] = (ew == 8'h00) & ef[5];
         ef[5] = ew == 8'h00;
         ef[2] = ew[7] ^ ef[4];
      end else ew = {m[0], m[7:1]};
      if (v && k inside {3'h2, 3'h4, 3'h5}) ea = ew;
      else if (l) ea = ~m;
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #8000;
      n_fail++;
      final_report;
   end
   initial begin
      void'($urandom(32'hDB094289));
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // values after reset, before any op
      @(negedge clk_sys);
      cmp_state({accumulator, mem_waddr, carry_flag, zero_flag, overflow_flag, aux_carry_flag, ext_sign_carry_flag,
         ext_zero_carry_flag, mem_we, 1'b0}, {rrsb_pkg::ACC_RST, rrsb_pkg::ADDR_RST, {6{rrsb_pkg::FLAG_RST}}, 2'b00});
      cmp_wdata(mem_wdata, 8'h00);
      $display("reset test done");
      @(posedge clk_sys);
      // boundary bytes, every code, each once without and once with acc_load racing it
      for (int i = 0; i < 32; i++) op(i[2:0], i[3] ? 8'hFF : 8'h01, i[4]);
      $display("directed test done");
      for (int i = 0; i < 500; i++) op($urandom, $urandom, $urandom);
      op(3'h0, 8'h00, 1'b0);
      op(3'h0, 8'h00, 1'b0);
      $display("random test done");
      final_report;
   end
endmodule
